// ==== fwp_pkg.sv ====
// shared constants for the flash write-protect and reset control block
package fwp_pkg;

  // serial framing
  localparam int unsigned FWP_BYTE_W = 8; // opcode and data bytes are eight bits
  localparam int unsigned FWP_BIT_CNT_W = 3; // counts bits inside one byte
  localparam int unsigned FWP_ADDR_BYTES = 3; // address bytes after an addressed opcode
  localparam int unsigned FWP_ADDR_W = FWP_ADDR_BYTES * FWP_BYTE_W; // full address width
  localparam logic [1:0] FWP_ADDR_LAST = 2'h2; // index of the final address byte

  // sector layout inside the address
  localparam int unsigned FWP_NUM_SECT = 8; // default sector count
  localparam int unsigned FWP_SECT_LSB = 17; // lowest address bit of the sector index

  // opcodes handled here; everything else is passed over
  localparam logic [7:0] FWP_OP_PAGE_PROG = 8'h82; // page program
  localparam logic [7:0] FWP_OP_BUF_PROG = 8'h83; // buffer to page program
  localparam logic [7:0] FWP_OP_PAGE_ERASE = 8'h81; // page erase
  localparam logic [7:0] FWP_OP_BLK_ERASE = 8'h50; // block erase
  localparam logic [7:0] FWP_OP_SECT_ERASE = 8'h7c; // sector erase
  localparam logic [7:0] FWP_OP_PROT_EN = 8'h3a; // enable software sector protection
  localparam logic [7:0] FWP_OP_PROT_DIS = 8'h3b; // disable software sector protection
  localparam logic [7:0] FWP_OP_MAP_WR = 8'h3c; // write the protection map
  localparam logic [7:0] FWP_OP_LOCK = 8'h3d; // sector lockdown

  // reset values
  localparam logic FWP_RST_WP_N = 1'b1; // write-protect sampled as released
  localparam logic FWP_RST_PIN_N = 1'b1; // reset pin sampled as released
  localparam logic FWP_RST_CS_N = 1'b1; // chip select sampled as released
  localparam logic FWP_RST_SW_EN = 1'b0; // software protection off

  // command state machine, one-hot
  typedef enum logic [5:0] {
    FWP_ST_IDLE = 6'h01, // waiting for chip select to fall
    FWP_ST_OPC = 6'h02, // shifting in the opcode
    FWP_ST_ADDR = 6'h04, // shifting in the address
    FWP_ST_DATA = 6'h08, // shifting in the map byte
    FWP_ST_WAIT = 6'h10, // waiting for chip select to rise
    FWP_ST_BUSY = 6'h20 // array operation running
  } fwp_state_t;

endpackage : fwp_pkg

// ==== fwp_sync.sv ====
// two-flop synchroniser for a group of pin inputs
module fwp_sync
  import fwp_pkg::*;
#(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  ////////////////////////////////////////////////////////////////////////////
  // one pair of flops per bit; stage one feeds only stage two
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_q; // first stage, read by stage two only
      logic sync_q; // second stage, safe to use
      always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          meta_q <= RST_VAL[g];
          sync_q <= RST_VAL[g];
        end else begin
          meta_q <= i_async[g];
          sync_q <= meta_q;
        end
      end
      assign o_sync[g] = sync_q;
    end
  endgenerate

endmodule : fwp_sync

// ==== fwp_shift.sv ====
// serial input shifter: bytes in on rising serial clock, msb first
module fwp_shift
  import fwp_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_clr,
  input wire logic i_sck_s,
  input wire logic i_si_s,
  output logic o_byte_vld,
  output logic [7:0] o_byte
);

  logic sck_prev_q, sck_prev_d; // last synced serial clock level
  logic [6:0] sh_q, sh_d; // bits gathered so far
  logic [FWP_BIT_CNT_W-1:0] cnt_q, cnt_d; // bits in the current byte
  logic vld_q, vld_d; // byte strobe
  logic [7:0] byte_q, byte_d; // completed byte
  logic sck_rise; // rising edge of the serial clock

  assign sck_rise = i_sck_s & ~sck_prev_q; // sample on rising edge

  ////////////////////////////////////////////////////////////////////////////
  // next values; clearing restarts byte alignment at chip select
  always_comb begin
    sck_prev_d = i_sck_s;
    sh_d = sh_q;
    cnt_d = cnt_q;
    vld_d = 1'b0;
    byte_d = byte_q;
    if (i_clr) begin
      cnt_d = '0;
      sh_d = '0;
    end else if (sck_rise) begin
      sh_d = {sh_q[5:0], i_si_s}; // first bit ends at the top
      cnt_d = cnt_q + 1'b1;
      if (cnt_q == FWP_BIT_CNT_W'(FWP_BYTE_W - 1)) begin
        vld_d = 1'b1;
        byte_d = {sh_q, i_si_s}; // msb first
      end
    end
  end

  // registers only
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sck_prev_q <= 1'b0;
      sh_q <= '0;
      cnt_q <= '0;
      vld_q <= 1'b0;
      byte_q <= '0;
    end else begin
      sck_prev_q <= sck_prev_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      vld_q <= vld_d;
      byte_q <= byte_d;
    end
  end

  assign o_byte_vld = vld_q;
  assign o_byte = byte_q;

endmodule : fwp_shift

// ==== fwp_protect_ctrl.sv ====
// write-protect gating and reset-pin control for the serial flash command path
//
// Function
// - write-protect blocks writes to mapped sectors
// - protection map frozen while write-protect low
// - protected program or erase does nothing
// - ignored command returns idle at deselect
// - protect-enable and lockdown work under write-protect
// - write-protect synchroniser resets to released; an unconnected pin is not pulled
// - reset pin aborts operation, forces idle
// - held in reset while pin low
// - pin high again resumes from idle
// - own power-on reset, no pin ordering
// - opcode then address, msb first
// - serial input sampled on rising clock
module fwp_protect_ctrl
  import fwp_pkg::*;
#(
  parameter int unsigned NUM_SECT = FWP_NUM_SECT
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_wp_n,
  input wire logic i_reset_n,
  input wire logic i_op_done,
  output logic o_op_start,
  output logic [7:0] o_op_code,
  output logic [FWP_ADDR_W-1:0] o_op_addr,
  output logic o_op_busy,
  output logic o_op_abort,
  output logic o_cmd_ignored,
  output logic o_idle,
  output logic o_in_reset,
  output logic o_wp_active,
  output logic o_sw_prot_en,
  output logic [NUM_SECT-1:0] o_prot_map,
  output logic [NUM_SECT-1:0] o_lock_map
);

  localparam int unsigned SECT_W = (NUM_SECT > 1) ? $clog2(NUM_SECT) : 1; // sector index width

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic cs_n_s; // chip select, synced
  logic sck_s; // serial clock, synced
  logic si_s; // serial data, synced
  logic wp_n_s; // write-protect, synced
  logic reset_n_s; // reset pin, synced

  // write-protect resets to released, as the pad pull-up would hold it
  fwp_sync #(
    .WIDTH(5),
    .RST_VAL({FWP_RST_CS_N, 1'b0, 1'b0, FWP_RST_WP_N, FWP_RST_PIN_N})
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_async({i_cs_n, i_sck, i_si, i_wp_n, i_reset_n}),
    .o_sync({cs_n_s, sck_s, si_s, wp_n_s, reset_n_s})
  );

  logic rst_pin; // reset pin held low, synchronous hold
  logic wp_act; // hardware write-protect asserted
  assign rst_pin = ~reset_n_s;
  assign wp_act = ~wp_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // chip select edges
  logic cs_prev_q, cs_prev_d; // previous synced chip select
  logic cs_fall; // frame start
  logic cs_rise; // frame end
  assign cs_fall = cs_prev_q & ~cs_n_s;
  assign cs_rise = ~cs_prev_q & cs_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // byte shifter, cleared outside frames and during pin reset
  logic byte_vld; // one byte complete
  logic [7:0] byte_in; // that byte
  logic shift_clr; // restart alignment

  assign shift_clr = cs_n_s | rst_pin; // no bits taken in reset

  fwp_shift u_shift (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_clr(shift_clr),
    .i_sck_s(sck_s),
    .i_si_s(si_s),
    .o_byte_vld(byte_vld),
    .o_byte(byte_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  // command state and protection storage
  fwp_state_t st_q, st_d; // command state
  logic [7:0] opc_q, opc_d; // latched opcode
  logic [FWP_ADDR_W-1:0] addr_q, addr_d; // latched address
  logic [1:0] abyte_q, abyte_d; // address byte index
  logic pend_q, pend_d; // accepted operation waiting for deselect
  logic sw_en_q, sw_en_d; // software protection enable
  logic [NUM_SECT-1:0] map_q, map_d; // protection map
  logic [NUM_SECT-1:0] lock_q, lock_d; // lockdown map, cleared only by power-on reset
  logic start_q, start_d; // operation start strobe
  logic abort_q, abort_d; // abort strobe
  logic ign_q, ign_d; // ignored command strobe

  logic is_pe; // opcode is program or erase
  logic [FWP_ADDR_W-1:0] addr_full; // address with the last byte
  logic [SECT_W-1:0] sect; // sector targeted
  logic sect_prot; // that sector may not be written

  // opcode class
  always_comb begin
    case (opc_q)
      FWP_OP_PAGE_PROG, FWP_OP_BUF_PROG, FWP_OP_PAGE_ERASE,
      FWP_OP_BLK_ERASE, FWP_OP_SECT_ERASE: is_pe = 1'b1;
      default: is_pe = 1'b0;
    endcase
  end

  assign addr_full = {addr_q[FWP_ADDR_W-9:0], byte_in};
  assign sect = addr_full[FWP_SECT_LSB +: SECT_W];
  // hardware path ignores the software enable; lockdown always holds
  assign sect_prot = lock_q[sect] | (map_q[sect] & (wp_act | sw_en_q));

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic; the pin reset overrides every branch
  always_comb begin
    st_d = st_q;
    opc_d = opc_q;
    addr_d = addr_q;
    abyte_d = abyte_q;
    pend_d = pend_q;
    sw_en_d = sw_en_q;
    map_d = map_q;
    lock_d = lock_q;
    start_d = 1'b0;
    abort_d = 1'b0;
    ign_d = 1'b0;
    cs_prev_d = cs_n_s;
    if (rst_pin) begin
      // stop whatever runs; stay idle while held
      abort_d = (st_q == FWP_ST_BUSY);
      st_d = FWP_ST_IDLE;
      pend_d = 1'b0;
    end else begin
      case (st_q)
        FWP_ST_IDLE: begin
          if (cs_fall) begin
            st_d = FWP_ST_OPC; // new frame after release
          end
        end
        FWP_ST_OPC: begin
          if (cs_rise) begin
            st_d = FWP_ST_IDLE;
          end else if (byte_vld) begin
            opc_d = byte_in;
            abyte_d = '0;
            st_d = FWP_ST_WAIT;
            case (byte_in)
              FWP_OP_PAGE_PROG, FWP_OP_BUF_PROG, FWP_OP_PAGE_ERASE,
              FWP_OP_BLK_ERASE, FWP_OP_SECT_ERASE, FWP_OP_LOCK: begin
                st_d = FWP_ST_ADDR; // address follows
              end
              FWP_OP_PROT_EN: begin
                sw_en_d = 1'b1; // accepted under write-protect
              end
              FWP_OP_PROT_DIS: begin
                sw_en_d = 1'b0; // hardware path still protects
              end
              FWP_OP_MAP_WR: begin
                if (wp_act) begin
                  ign_d = 1'b1; // map frozen
                end else begin
                  st_d = FWP_ST_DATA;
                end
              end
              default: begin
                st_d = FWP_ST_WAIT; // other commands handled elsewhere
              end
            endcase
          end
        end
        FWP_ST_ADDR: begin
          if (cs_rise) begin
            st_d = FWP_ST_IDLE; // short address, nothing done
          end else if (byte_vld) begin
            addr_d = addr_full;
            abyte_d = abyte_q + 2'h1;
            if (abyte_q == FWP_ADDR_LAST) begin
              st_d = FWP_ST_WAIT;
              if (opc_q == FWP_OP_LOCK) begin
                lock_d[sect] = 1'b1; // lockdown taken under write-protect
              end else if (is_pe && sect_prot) begin
                ign_d = 1'b1; // checked before any start, discarded
              end else begin
                pend_d = 1'b1;
              end
            end
          end
        end
        FWP_ST_DATA: begin
          if (cs_rise) begin
            st_d = FWP_ST_IDLE;
          end else if (byte_vld) begin
            st_d = FWP_ST_WAIT;
            if (wp_act) begin
              ign_d = 1'b1; // write-protect fell mid-frame
            end else begin
              map_d = byte_in[NUM_SECT-1:0];
            end
          end
        end
        FWP_ST_WAIT: begin
          if (cs_rise) begin
            st_d = pend_q ? FWP_ST_BUSY : FWP_ST_IDLE; // ignored one goes idle
            start_d = pend_q;
            pend_d = 1'b0;
          end
        end
        FWP_ST_BUSY: begin
          if (i_op_done) begin
            st_d = FWP_ST_IDLE;
          end
        end
        default: begin
          st_d = FWP_ST_IDLE;
          pend_d = 1'b0;
        end
      endcase
    end
  end

  // registers only; power-on reset clears everything but cs_prev_q, which loads released
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= FWP_ST_IDLE;
      opc_q <= '0;
      addr_q <= '0;
      abyte_q <= '0;
      pend_q <= 1'b0;
      sw_en_q <= FWP_RST_SW_EN;
      map_q <= '0;
      lock_q <= '0;
      start_q <= 1'b0;
      abort_q <= 1'b0;
      ign_q <= 1'b0;
      cs_prev_q <= FWP_RST_CS_N;
    end else begin
      st_q <= st_d;
      opc_q <= opc_d;
      addr_q <= addr_d;
      abyte_q <= abyte_d;
      pend_q <= pend_d;
      sw_en_q <= sw_en_d;
      map_q <= map_d;
      lock_q <= lock_d;
      start_q <= start_d;
      abort_q <= abort_d;
      ign_q <= ign_d;
      cs_prev_q <= cs_prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  assign o_op_start = start_q;
  assign o_op_code = opc_q;
  assign o_op_addr = addr_q;
  assign o_op_busy = (st_q == FWP_ST_BUSY);
  assign o_op_abort = abort_q;
  assign o_cmd_ignored = ign_q;
  assign o_idle = (st_q == FWP_ST_IDLE);
  assign o_in_reset = rst_pin;
  assign o_wp_active = wp_act;
  assign o_sw_prot_en = sw_en_q;
  assign o_prot_map = map_q;
  assign o_lock_map = lock_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic last_addr; // final address byte arrives this cycle
  assign last_addr = (st_q == FWP_ST_ADDR) && byte_vld && !cs_rise && !rst_pin &&
    (abyte_q == FWP_ADDR_LAST);

  sequence s_rel;
    $fell(rst_pin) ##0 (st_q == FWP_ST_IDLE);
  endsequence

  sequence s_frame_open;
    cs_fall && !rst_pin && (st_q == FWP_ST_IDLE);
  endsequence

  map_frozen_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    $past(wp_act) && wp_act |-> $stable(map_q)
  ) else $error("protection map changed under write-protect");

  wp_block_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    last_addr && is_pe && wp_act && map_q[sect] |=> !pend_q && o_cmd_ignored
  ) else $error("protected sector accepted under write-protect");

  ign_no_op_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    o_cmd_ignored |-> !pend_q ##1 !o_op_start
  ) else $error("ignored command started an operation");

  ign_idle_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (st_q == FWP_ST_WAIT) && !pend_q && cs_rise && !rst_pin |=> o_idle && !o_op_start
  ) else $error("ignored command did not return to idle");

  lock_wp_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    last_addr && (opc_q == FWP_OP_LOCK) |=> lock_q[$past(sect)]
  ) else $error("lockdown not applied");

  rst_abort_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    rst_pin && o_op_busy |=> o_op_abort && o_idle
  ) else $error("reset pin did not abort the operation");

  rst_hold_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    rst_pin [*2] |-> o_idle && !o_op_start && !pend_q
  ) else $error("activity while reset pin held");

  rst_resume_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    s_rel ##[1:20] s_frame_open |=> (st_q == FWP_ST_OPC)
  ) else $error("frame not accepted after reset release");

  start_chk_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (st_q == FWP_ST_WAIT) && pend_q && cs_rise && !rst_pin |=> o_op_start ##0 o_op_busy
  ) else $error("accepted operation did not start at deselect");

endmodule : fwp_protect_ctrl

// ==== fwp_host_model.sv ====
// host processor model: drives select, serial clock, data and control pins
module fwp_host_model (
  input wire logic i_ref_clk,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si,
  output logic o_wp_n,
  output logic o_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;

  int half_clks = 3; // sck half period in ref clocks; 3 is the fastest legal

  ////////////////////////////////////////////////////////////////////////////////
  // idle pin levels
  initial begin
    o_cs_n = 1'b1; // deselected
    o_sck = 1'b0; // clock stands still outside frames
    o_si = 1'b0;
    o_wp_n = 1'b1; // write-protect released
    o_reset_n = 1'b1; // reset pin released, driven high, not left floating
  end

  // wait n ref clocks, then a small fixed skew off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : tick

  // control pins; sync latency covered by the wait
  task automatic pins(input logic wp_n, input logic reset_n);
    tick(1);
    o_wp_n = wp_n;
    o_reset_n = reset_n;
    tick(4);
  endtask : pins

  ////////////////////////////////////////////////////////////////////////////////
  // framing
  task automatic open_frame();
    tick(1);
    o_cs_n = 1'b0; // instruction opens on falling select
    tick(half_clks);
  endtask : open_frame

  task automatic shift_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      o_si = b[i]; // msb first
      tick(half_clks);
      o_sck = 1'b1; // device samples on this rise
      tick(half_clks);
      o_sck = 1'b0;
    end
  endtask : shift_byte

  // released data line shows no stale level; wait lets start land
  task automatic close_frame();
    tick(half_clks);
    o_cs_n = 1'b1;
    o_si = ~o_si;
    tick(6);
  endtask : close_frame

  task automatic cmd(input logic [7:0] opc);
    open_frame();
    shift_byte(opc);
    close_frame();
  endtask : cmd

  task automatic cmd_addr(input logic [7:0] opc, input logic [23:0] addr);
    open_frame();
    shift_byte(opc);
    shift_byte(addr[23:16]);
    shift_byte(addr[15:8]);
    shift_byte(addr[7:0]);
    close_frame();
  endtask : cmd_addr

  task automatic cmd_data(input logic [7:0] opc, input logic [7:0] dat);
    open_frame();
    shift_byte(opc);
    shift_byte(dat);
    close_frame();
  endtask : cmd_data
endmodule : fwp_host_model

// ==== fwp_protect_ctrl_tb.sv ====
// self-checking testbench for the write-protect and reset-pin control block
module fwp_protect_ctrl_tb
  import fwp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk; // 10 MHz device clock
  logic rstn; // power-on reset
  logic op_done; // array side completion
  wire logic cs_n, sck, si, wp_n, reset_n;
  logic op_start, op_busy, op_abort, cmd_ignored, idle, in_reset, wp_active, sw_prot_en;
  logic [7:0] op_code, prot_map, lock_map;
  logic [FWP_ADDR_W-1:0] op_addr;
  int fails = 0;
  int comparisons = 0;
  int starts = 0; // counted one-cycle pulses
  int ignores = 0;
  int aborts = 0;
  int s0, i0, a0;
  logic [7:0] ops [5] = '{FWP_OP_PAGE_PROG, FWP_OP_BUF_PROG, FWP_OP_PAGE_ERASE,
    FWP_OP_BLK_ERASE, FWP_OP_SECT_ERASE};

  fwp_protect_ctrl #(.NUM_SECT(8)) fwp_protect_ctrl_inst (
    .i_ref_clk(ref_clk), .i_rstn(rstn), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
    .i_wp_n(wp_n), .i_reset_n(reset_n), .i_op_done(op_done), .o_op_start(op_start),
    .o_op_code(op_code), .o_op_addr(op_addr), .o_op_busy(op_busy), .o_op_abort(op_abort),
    .o_cmd_ignored(cmd_ignored), .o_idle(idle), .o_in_reset(in_reset),
    .o_wp_active(wp_active), .o_sw_prot_en(sw_prot_en), .o_prot_map(prot_map),
    .o_lock_map(lock_map));

  fwp_host_model fwp_host_model_inst (
    .i_ref_clk(ref_clk), .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .o_wp_n(wp_n),
    .o_reset_n(reset_n));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and pulse counters; one-cycle pulses are looked at mid-cycle, where they are settled
  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  always @(negedge ref_clk) begin
    if (op_start === 1'b1) starts++;
    if (cmd_ignored === 1'b1) ignores++;
    if (op_abort === 1'b1) aborts++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  // array reports completion; machine must fall back to idle
  task automatic finish_op();
    op_done = 1'b1;
    step(1);
    op_done = 1'b0;
    step(2);
    check(op_busy, 1'b0, "busy after done");
    check(idle, 1'b1, "idle after done");
  endtask : finish_op

  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_power_on();
    check(idle, 1'b1, "idle after power-on");
    check(wp_active, 1'b0, "write-protect released");
    check(in_reset, 1'b0, "reset pin released");
    check(prot_map, 8'h00, "map cleared");
  endtask : t_power_on

  // unprotected program at slow sck, then a frame while busy is ignored
  task automatic t_prog_free();
    fwp_host_model_inst.half_clks = 6;
    s0 = starts;
    fwp_host_model_inst.cmd_addr(FWP_OP_PAGE_PROG, 24'h0a5c3f);
    check(starts - s0, 1, "start count");
    check(op_code, FWP_OP_PAGE_PROG, "opcode");
    check(op_addr, 24'h0a5c3f, "address");
    check(op_busy, 1'b1, "busy");
    fwp_host_model_inst.cmd_addr(FWP_OP_BLK_ERASE, 24'h000000);
    check(starts - s0, 1, "no start while busy");
    finish_op();
    fwp_host_model_inst.half_clks = 3;
  endtask : t_prog_free

  task automatic t_map_freeze();
    fwp_host_model_inst.cmd_data(FWP_OP_MAP_WR, 8'h01);
    check(prot_map, 8'h01, "map written");
    fwp_host_model_inst.pins(1'b0, 1'b1);
    check(wp_active, 1'b1, "wp seen");
    i0 = ignores;
    fwp_host_model_inst.cmd_data(FWP_OP_MAP_WR, 8'hff);
    check(prot_map, 8'h01, "map frozen");
    check(ignores - i0, 1, "map write refused");
  endtask : t_map_freeze

  // every program and erase code to mapped sector 0, software protection off
  task automatic t_wp_block();
    foreach (ops[k]) begin
      s0 = starts;
      i0 = ignores;
      fwp_host_model_inst.cmd_addr(ops[k], 24'h000000);
      check(starts - s0, 0, "protected start");
      check(ignores - i0, 1, "protected ignored");
      check(idle, 1'b1, "idle after deselect");
    end
    s0 = starts;
    fwp_host_model_inst.cmd_addr(FWP_OP_SECT_ERASE, 24'h040000);
    check(starts - s0, 1, "unmapped sector starts");
    finish_op();
  endtask : t_wp_block

  task automatic t_wp_allowed();
    fwp_host_model_inst.cmd(FWP_OP_PROT_EN);
    check(sw_prot_en, 1'b1, "protect enable under wp");
    fwp_host_model_inst.cmd_addr(FWP_OP_LOCK, 24'h060000);
    check(lock_map, 8'h08, "lockdown under wp");
    fwp_host_model_inst.cmd(FWP_OP_PROT_DIS);
    check(sw_prot_en, 1'b0, "protect disable under wp");
    fwp_host_model_inst.pins(1'b1, 1'b1);
    s0 = starts;
    i0 = ignores;
    fwp_host_model_inst.cmd_addr(FWP_OP_PAGE_PROG, 24'h060000);
    check(ignores - i0, 1, "locked sector refused");
    check(starts - s0, 0, "locked sector no start");
  endtask : t_wp_allowed

  // second power-on reset mid-run clears lockdown, then commands work again
  task automatic t_por();
    rstn = 1'b0;
    step(2);
    check(lock_map, 8'h00, "lockdown cleared by power-on reset");
    rstn = 1'b1;
    step(4);
    check(idle, 1'b1, "idle after second release");
    check(prot_map, 8'h00, "map cleared again");
    s0 = starts;
    fwp_host_model_inst.cmd_addr(FWP_OP_PAGE_PROG, 24'h060000);
    check(starts - s0, 1, "formerly locked sector starts");
    finish_op();
  endtask : t_por

  // abort mid-operation, frame refused while held, resume afterwards
  task automatic t_reset_pin();
    fwp_host_model_inst.cmd_addr(FWP_OP_PAGE_PROG, 24'h040000);
    check(op_busy, 1'b1, "busy before reset");
    a0 = aborts;
    fwp_host_model_inst.pins(1'b1, 1'b0);
    check(aborts - a0, 1, "abort pulse");
    check(op_busy, 1'b0, "busy dropped");
    check(idle, 1'b1, "forced idle");
    check(in_reset, 1'b1, "held in reset");
    s0 = starts;
    fwp_host_model_inst.cmd_addr(FWP_OP_PAGE_PROG, 24'h040000);
    check(starts - s0, 0, "no command in reset");
    fwp_host_model_inst.pins(1'b1, 1'b1);
    check(in_reset, 1'b0, "reset released");
    fwp_host_model_inst.cmd_addr(FWP_OP_PAGE_PROG, 24'h040000);
    check(starts - s0, 1, "resumed");
    finish_op();
  endtask : t_reset_pin

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    rstn = 1'b0;
    op_done = 1'b0;
    step(4);
    rstn = 1'b1;
    step(4); // select stays high a few clocks after release
    t_power_on();
    t_prog_free();
    t_map_freeze();
    t_wp_block();
    t_wp_allowed();
    t_reset_pin();
    t_por();
    results();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    results();
  end
endmodule : fwp_protect_ctrl_tb
